/* File: verification/axis_chk_sva.sv */
`timescale 1ns/1ps
module axis_chk
    import axis_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pslverr_o,
    input wire logic target_reached_i,
    input wire logic dir_ccw_o,
    input wire logic move_start_o,
    input wire logic home_valid_o,
    input wire logic multi_rev_travel_warning_o,
    input wire logic restore_ok_o
);
    // ----------
    // bus shadow
    // ----------
    logic sgn_reg;
    logic rel_reg;
    wire logic wr_w = psel_i && penable_i && pwrite_i;
    // last target sign and move kind; only the bus shows them
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sgn_reg <= 1'b0;
            rel_reg <= 1'b0;
        end else if (wr_w && paddr_i == TARGET_OFF) begin
            sgn_reg <= pwdata_i[31];
        end else if (wr_w && paddr_i == CMD_OFF && pwdata_i[START_BIT]) begin
            rel_reg <= pwdata_i[REL_BIT];
        end
    end
    // ----------
    // properties
    // ----------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    pulse_once_a: assert property (move_start_o |=> !move_start_o) else $error("start pulse too long");
    start_gate_a: assert property (move_start_o |-> $past(target_reached_i)) else $error("start while moving");
    dir_hold_a: assert property ($changed(dir_ccw_o) |-> move_start_o) else $error("direction moved alone");
    rel_dir_a: assert property (move_start_o && rel_reg |-> dir_ccw_o == !sgn_reg) else $error("relative dir");
    warn_home_a: assert property ($rose(multi_rev_travel_warning_o) |-> !home_valid_o) else $error("home kept");
    restore_ok_a: assert property (restore_ok_o |-> home_valid_o && !multi_rev_travel_warning_o)
        else $error("restore without home");
    unmapped_err_a: assert property (psel_i && penable_i && paddr_i > STATE_OFF |-> pslverr_o)
        else $error("unmapped not refused");
    read_idle_a: assert property (!(psel_i && penable_i && !pwrite_i) |-> prdata_o == 32'h0)
        else $error("read data outside read");
    cover property (move_start_o && dir_ccw_o);
    cover property (move_start_o && !dir_ccw_o);
    cover property ($rose(multi_rev_travel_warning_o));
endmodule
bind degree_axis_direction axis_chk u_chk (.*);

/* File: verification/motor_model.sv */
`timescale 1ns/1ps
module motor_model (
    input wire logic ref_clk_i,
    input wire logic move_start_i,
    output logic [18:0] cur_pos_o,
    output logic target_reached_o,
    output logic rev_step_o,
    output logic rev_dir_ccw_o
);
    int hold = 2;
    int left = 0;
    // ----------
    // motion
    // ----------
    initial begin
        cur_pos_o = 19'h0;
        target_reached_o = 1'b1;
        rev_step_o = 1'b0;
        rev_dir_ccw_o = 1'b1;
    end
    // busy for hold plus one cycles after a start, so slow moves can be staged
    always @(posedge ref_clk_i) begin
        if (move_start_i) begin
            target_reached_o <= 1'b0;
            left <= hold;
        end else if (left > 0) begin
            left <= left - 1;
        end else begin
            target_reached_o <= 1'b1;
        end
    end
    // one revolution pulse every other cycle, never reversing
    task automatic spin(input int n, input logic ccw);
        rev_dir_ccw_o <= ccw;
        repeat (n) begin
            @(posedge ref_clk_i);
            rev_step_o <= 1'b1;
            @(posedge ref_clk_i);
            rev_step_o <= 1'b0;
        end
    endtask
endmodule

/* File: verification/tb.sv */
`timescale 1ns/1ps
module tb;
    import axis_pkg::*;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h0;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic pready_o, pslverr_o, dir_ccw_o, move_start_o, home_valid_o, restore_ok_o, irq_o, err;
    logic [18:0] cur_pos_i;
    logic target_reached_i, rev_step_i, rev_dir_ccw_i, multi_rev_travel_warning_o;
    int errors = 0, checked = 0;
    degree_axis_direction DUT (.*);
    motor_model m (.ref_clk_i(ref_clk_i), .move_start_i(move_start_o), .cur_pos_o(cur_pos_i),
        .target_reached_o(target_reached_i), .rev_step_o(rev_step_i), .rev_dir_ccw_o(rev_dir_ccw_i));
    initial forever #2.5 ref_clk_i = ~ref_clk_i;
    // ----------
    // helpers
    // ----------
    task summarize;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task tmo(input int n, input int lim);
        if (n >= lim) begin
            errors++;
            summarize;
        end
    endtask
    // one apb transfer; an idle edge first keeps psel from two writes in one step
    // the answer is taken at the rising edge where pready is seen high
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 9);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        tmo(n, 9);
    endtask
    task automatic reach;
        int n = 0;
        repeat (2) @(negedge ref_clk_i);
        do begin
            @(negedge ref_clk_i);
            n++;
        end while (target_reached_i !== 1'b1 && n < 99);
        tmo(n, 99);
    endtask
    // a control word of zero leaves the pending policy alone
    task automatic go(input logic [31:0] c, input logic [18:0] p, input logic [31:0] t, input logic [31:0] k,
        input logic e);
        int n = 0;
        m.cur_pos_o <= p;
        if (c != 32'h0) bus(1'b1, CTRL_OFF, c);
        bus(1'b1, TARGET_OFF, t);
        bus(1'b1, CMD_OFF, k);
        do begin
            @(negedge ref_clk_i);
            n++;
        end while (move_start_o !== 1'b1 && n < 9);
        tmo(n, 9);
        chk({31'h0, dir_ccw_o}, {31'h0, e});
        reach;
    endtask
    // ----------
    // scenarios
    // ----------
    task automatic policies;
        go(32'h54, 19'h0, 32'h00041EB0, 32'h1, 1'b1);
        go(32'h54, 19'h0, 32'hFFFEA070, 32'h1, 1'b0);
        bus(1'b0, POS_OFF, 32'h0);
        chk(rd, 32'h00041EB0);
        go(32'h54, 19'h0, 32'hFFFA81C0, 32'h1, 1'b0);
        go(32'h54, 19'h0, 32'h00057E40, 32'h1, 1'b1);
        go(32'h54, 19'h5, 32'h0, 32'h1, 1'b1);
        go(32'h55, 19'h2BF20, 32'h00041EB0, 32'h1, 1'b1);
        go(32'h55, 19'h2BF20, 32'hFFFEA070, 32'h1, 1'b1);
        go(32'h55, 19'h0, 32'h00041EB0, 32'h1, 1'b0);
        go(32'h55, 19'h15F90, 32'h00041EB0, 32'h1, 1'b1);
        go(32'h56, 19'h0, 32'h00041EB0, 32'h1, 1'b0);
        go(32'h56, 19'h0, 32'hFFFBE150, 32'h1, 1'b0);
        go(32'h57, 19'h0, 32'h00041EB0, 32'h1, 1'b1);
        go(32'h57, 19'h0, 32'hFFFBE150, 32'h1, 1'b1);
        go(32'h56, 19'h0, 32'h000003E8, 32'h3, 1'b1);
        go(32'h57, 19'h0, 32'hFFFFFC18, 32'h3, 1'b0);
    endtask
    task automatic midmove;
        m.hold = 30;
        bus(1'b1, CTRL_OFF, 32'h57);
        bus(1'b1, TARGET_OFF, 32'h00041EB0);
        bus(1'b1, CMD_OFF, 32'h1);
        bus(1'b1, CTRL_OFF, 32'h56);
        bus(1'b1, CMD_OFF, 32'h1);
        @(negedge ref_clk_i);
        chk({30'h0, move_start_o, dir_ccw_o}, 32'h1);
        m.hold = 2;
        reach;
        go(32'h0, 19'h0, 32'h00041EB0, 32'h1, 1'b0);
    endtask
    task automatic revs;
        bus(1'b1, CTRL_OFF, 32'h54);
        bus(1'b1, CMD_OFF, 32'h4);
        m.spin(32'h8000, 1'b1);
        @(negedge ref_clk_i);
        chk({home_valid_o, multi_rev_travel_warning_o, restore_ok_o}, 32'h5);
        bus(1'b1, CTRL_OFF, 32'h0);
        repeat (2) @(negedge ref_clk_i);
        chk({home_valid_o, multi_rev_travel_warning_o, restore_ok_o}, 32'h4);
        bus(1'b1, MASK_OFF, 32'h2);
        bus(1'b1, CTRL_OFF, 32'h40);
        repeat (2) @(negedge ref_clk_i);
        chk({home_valid_o, multi_rev_travel_warning_o, restore_ok_o, irq_o}, 32'h5);
        bus(1'b0, STATUS_OFF, 32'h0);
        chk(rd & 32'h6, 32'h6);
        @(negedge ref_clk_i);
        chk({31'h0, irq_o}, 32'h0);
        bus(1'b0, 12'h020, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask
    initial begin
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        bus(1'b0, CTRL_OFF, 32'h0);
        chk({rd[30:0], dir_ccw_o}, 32'h81);
        chk({31'h0, pready_o}, 32'h1);
        policies;
        midmove;
        revs;
        summarize;
    end
endmodule

/* File: verilog/axis_pkg.sv */
//--------------------------------------------------------------
//--------------------------------------------------------------
package axis_pkg;

    // register byte offsets
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] TARGET_OFF = 12'h004;
    localparam logic [11:0] CMD_OFF = 12'h008;
    localparam logic [11:0] STATUS_OFF = 12'h00C;
    localparam logic [11:0] MASK_OFF = 12'h010;
    localparam logic [11:0] POS_OFF = 12'h014;
    localparam logic [11:0] REV_OFF = 12'h018;
    localparam logic [11:0] STATE_OFF = 12'h01C;

    // ctrl fields
    localparam int POLICY_LSB = 0;
    localparam int UNIT_LSB = 2;
    localparam int MODE_LSB = 4;
    localparam int WARN_EN_BIT = 6;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0040;

    // cmd fields
    localparam int START_BIT = 0;
    localparam int REL_BIT = 1;
    localparam int HOME_SET_BIT = 2;

    // status bits
    localparam int EV_START = 0;
    localparam int EV_WARN = 1;
    localparam int EV_HOME_LOST = 2;
    localparam int EV_W = 3;

    localparam logic [18:0] POS_FULL = 19'h57E40; // 360000 counts
    localparam logic [18:0] POS_MAX = 19'h57E3F; // 359999
    localparam logic [18:0] POS_HALF = 19'h2BF20; // 180000
    localparam logic [15:0] REV_LIMIT = 16'h8000; // 32768 rev

    typedef enum logic [1:0] {POL_SIGN, POL_SHORT, POL_DEC, POL_INC} policy_t;
    typedef enum logic [1:0] {UNIT_PULSE, UNIT_DEGREE, UNIT_MM, UNIT_INCH} unit_t;
    typedef enum logic [1:0] {MODE_CYCLIC, MODE_PROFILE, MODE_POINT, MODE_RSVD} mode_t;
    typedef enum {ST_IDLE, ST_MOVE} move_state_t;

endpackage

/* File: verilog/degree_axis_direction.sv */
`timescale 1ns/1ps
module degree_axis_direction
    import axis_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [18:0] cur_pos_i,
    input wire logic target_reached_i,
    input wire logic rev_step_i,
    input wire logic rev_dir_ccw_i,
    output logic dir_ccw_o,
    output logic move_start_o,
    output logic home_valid_o,
    output logic multi_rev_travel_warning_o,
    output logic restore_ok_o,
    output logic irq_o
);

    //--------------------------------------------------------------
    // register state
    //--------------------------------------------------------------
    logic [31:0] ctrl_reg;
    logic [31:0] target_reg;
    logic [EV_W-1:0] status_reg;
    logic [EV_W-1:0] mask_reg;
    logic [1:0] policy_reg;
    logic dir_reg;
    logic start_reg;
    logic home_reg;
    logic warn_reg;
    logic [15:0] rev_cnt_reg;
    logic rev_dir_reg;
    move_state_t state_reg;

    // bus decode, direction, warning and event nets, all combinational
    // acc is the access phase; wr and rd add the address check
    logic acc;
    logic wr;
    logic rd;
    logic mapped;
    logic start_cmd;
    logic dir_next;
    logic inf_feed;
    logic warn_active;
    logic warn_hit;
    logic [18:0] tgt_mod;
    logic [18:0] ccw_dist;
    logic [18:0] cw_dist;
    logic [EV_W-1:0] ev_set;

    // typed views of control fields, read only by the inf_feed decode
    unit_t unit_sel;
    mode_t mode_sel;

    // fold a signed thousandth-degree target into 0..359999
    // plus or minus one turn folds to zero, so the sign policy
    // tells the minus 360 case apart only through the sign bit
    function automatic logic [18:0] wrap_pos(input logic [31:0] t);
        logic signed [31:0] r;
        r = $signed(t) % $signed({13'h0000, POS_FULL});
        if (r < 0) begin
            r = r + $signed({13'h0000, POS_FULL});
        end
        return r[18:0];
    endfunction

    // address match against the word map; used by decode and error path
    // unmapped words answer with an error rather than reading zero
    function automatic logic is_map(input logic [11:0] a);
        return a == CTRL_OFF || a == TARGET_OFF || a == CMD_OFF || a == STATUS_OFF
            || a == MASK_OFF || a == POS_OFF || a == REV_OFF || a == STATE_OFF;
    endfunction

    //--------------------------------------------------------------
    // apb decode
    //--------------------------------------------------------------
    // zero wait state slave, errors on unmapped addresses
    // pready stands high so the master never waits; writes land
    // on the access edge, reads drive data only in the access cycle
    // a refused access changes no state at all
    assign acc = psel_i && penable_i;
    assign mapped = is_map(paddr_i);
    assign wr = acc && pwrite_i && mapped;
    assign rd = acc && !pwrite_i && mapped;
    assign pready_o = 1'b1;
    assign pslverr_o = acc && !mapped;
    assign start_cmd = wr && paddr_i == CMD_OFF && pwdata_i[START_BIT];

    assign unit_sel = unit_t'(ctrl_reg[UNIT_LSB +: 2]);
    assign mode_sel = mode_t'(ctrl_reg[MODE_LSB +: 2]);

    // infinite feed only in degree units and profile or point mode
    // cyclic mode is pulse only, so a degree code there still warns
    // warn_hit fires once; warn_reg blocks repeats until cleared
    assign inf_feed = unit_sel == UNIT_DEGREE
        && (mode_sel == MODE_PROFILE || mode_sel == MODE_POINT);
    assign warn_active = ctrl_reg[WARN_EN_BIT] && !inf_feed;
    assign warn_hit = warn_active && rev_cnt_reg >= REV_LIMIT && !warn_reg;

    //--------------------------------------------------------------
    // direction choice
    //--------------------------------------------------------------
    assign tgt_mod = wrap_pos(target_reg);
    // distances modulo one turn; cur is assumed within range
    // a position above 359999 from the motor gives a wrong choice,
    // traded for one subtractor instead of a second wrap
    assign ccw_dist = (tgt_mod >= cur_pos_i) ? tgt_mod - cur_pos_i
        : 19'(tgt_mod + POS_FULL - cur_pos_i);
    assign cw_dist = (ccw_dist == 19'h00000) ? 19'h00000 : 19'(POS_FULL - ccw_dist);

    // direction for the next start; relative moves bypass the policy
    // the live command word is looked at, since dir_next is only
    // used in the cycle in which the start command is written
    always_comb begin
        dir_next = 1'b1;
        if (pwdata_i[REL_BIT]) begin
            dir_next = !target_reg[31];
        end else begin
            case (policy_t'(policy_reg))
                POL_SIGN: dir_next = !target_reg[31];
                POL_SHORT: dir_next = ccw_dist <= cw_dist;
                POL_DEC: dir_next = 1'b0;
                POL_INC: dir_next = 1'b1;
                default: dir_next = 1'b1;
            endcase
        end
    end

    //--------------------------------------------------------------
    // registers
    //--------------------------------------------------------------
    // configuration writes
    // only the defined control bits are kept, so reads show zeros above
    // the target is stored raw and folded later, keeping its sign
    // for the sign policy and for relative moves
    // refused and unmapped writes never reach these registers
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_reg <= CTRL_RESET;
            target_reg <= 32'h0000_0000;
            mask_reg <= '0;
        end else if (wr) begin
            if (paddr_i == CTRL_OFF) begin
                ctrl_reg <= {25'h0000000, pwdata_i[6:0]};
            end
            if (paddr_i == TARGET_OFF) begin
                target_reg <= pwdata_i;
            end
            if (paddr_i == MASK_OFF) begin
                mask_reg <= pwdata_i[EV_W-1:0];
            end
        end
    end

    // policy latched only when idle, so a mid-move change waits
    // the copy happens every idle cycle with the motor at target,
    // so a start taken at the second idle edge or later sees the newest stopped setting
    // a change written while moving is held back until then
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            policy_reg <= 2'h0;
        end else if (state_reg == ST_IDLE && target_reached_i) begin
            policy_reg <= ctrl_reg[POLICY_LSB +: 2];
        end
    end

    // move sequencing; starts during a move are dropped
    // the start pulse lasts one cycle; the move ends only after the
    // pulse, so a motor that still shows target reached for one
    // cycle after the start cannot end the move at once
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            dir_reg <= 1'b1;
            start_reg <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (start_cmd && target_reached_i) begin
                        dir_reg <= dir_next;
                        start_reg <= 1'b1;
                        state_reg <= ST_MOVE;
                    end
                end
                ST_MOVE: begin
                    if (!start_reg && target_reached_i) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // same-direction revolution count, reset by reversal
    // the count saturates instead of wrapping, so a very long run
    // in one direction cannot fall back under the warning limit
    // a reversal restarts at one, the step that reversed counts
    // limitation: the count is not kept across a reset
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rev_cnt_reg <= 16'h0000;
            rev_dir_reg <= 1'b1;
        end else if (rev_step_i) begin
            rev_dir_reg <= rev_dir_ccw_i;
            if (rev_dir_ccw_i != rev_dir_reg) begin
                rev_cnt_reg <= 16'h0001;
            end else if (rev_cnt_reg != 16'hFFFF) begin
                rev_cnt_reg <= rev_cnt_reg + 16'h0001;
            end
        end
    end

    // warning and home position
    // the overflow wins over a home set in the same cycle, so a home
    // written at the moment of overflow is still cleared
    // a home set clears the warning; it sets again next cycle if the
    // count is still over the limit and warnings are active
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            warn_reg <= 1'b0;
            home_reg <= 1'b0;
        end else begin
            if (warn_hit) begin
                warn_reg <= 1'b1;
                home_reg <= 1'b0;
            end else if (wr && paddr_i == CMD_OFF && pwdata_i[HOME_SET_BIT]) begin
                home_reg <= 1'b1;
                warn_reg <= 1'b0;
            end else if (!warn_active) begin
                warn_reg <= 1'b0;
            end
        end
    end

    //--------------------------------------------------------------
    // event sources
    //--------------------------------------------------------------
    // home loss is only an event when a home was actually held
    always_comb begin
        ev_set = '0;
        ev_set[EV_START] = start_reg;
        ev_set[EV_WARN] = warn_hit;
        ev_set[EV_HOME_LOST] = warn_hit && home_reg;
    end

    // sticky events; set beats read clear
    // a read in the cycle of a new event keeps that event, so no
    // event is lost between the read and the clear
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_reg <= '0;
        end else if (rd && paddr_i == STATUS_OFF) begin
            status_reg <= ev_set;
        end else begin
            status_reg <= status_reg | ev_set;
        end
    end

    // read data
    // zero outside a mapped read, so an idle bus shows no stale data
    // cmd is write only and reads as zero
    always_comb begin
        prdata_o = 32'h0000_0000;
        if (rd) begin
            case (paddr_i)
                CTRL_OFF: prdata_o = ctrl_reg;
                TARGET_OFF: prdata_o = target_reg;
                STATUS_OFF: prdata_o = {29'h0, status_reg};
                MASK_OFF: prdata_o = {29'h0, mask_reg};
                POS_OFF: prdata_o = {13'h0000, tgt_mod};
                REV_OFF: prdata_o = {16'h0000, rev_cnt_reg};
                STATE_OFF: prdata_o = {26'h0, policy_reg, restore_ok_o, home_reg, dir_reg,
                    state_reg == ST_MOVE};
                default: prdata_o = 32'h0000_0000;
            endcase
        end
    end

    //--------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------
    // all but restore_ok and irq come straight from flip-flops
    assign dir_ccw_o = dir_reg;
    assign move_start_o = start_reg;
    assign home_valid_o = home_reg;
    assign multi_rev_travel_warning_o = warn_reg;
    assign restore_ok_o = home_reg && (inf_feed || warn_active);
    assign irq_o = |(status_reg & mask_reg);

endmodule
